// file: common/sacr_defines.vh
// Register offsets, field positions and reset values of the aux control bank
`ifndef SACR_DEFINES_VH
`define SACR_DEFINES_VH

// ****************************************************************
// Register addresses on the special function register bus
// ****************************************************************
`define SACR_ADDR_PWR3      8'h45
`define SACR_ADDR_PROT      8'h48
`define SACR_ADDR_DEV0      8'h4C
`define SACR_ADDR_AUX0      8'hA1
`define SACR_ADDR_AUX1      8'hA2
`define SACR_ADDR_AUX2      8'hA3

// ****************************************************************
// Reset values
// ****************************************************************
`define SACR_RST_PWR3       8'h00
`define SACR_RST_PROT       8'h00
`define SACR_RST_DEV0       8'h83
`define SACR_RST_AUX0       8'h00
`define SACR_RST_AUX1       8'h00
`define SACR_RST_AUX2       8'h00

// ****************************************************************
// Writable bit masks (reserved bits read as zero)
// ****************************************************************
`define SACR_MASK_PWR3      8'h80
`define SACR_MASK_PROT      8'h77
`define SACR_MASK_DEV0      8'hE7
`define SACR_MASK_AUX0      8'hF3
`define SACR_MASK_AUX1      8'h31
`define SACR_MASK_AUX2      8'hCF

// ****************************************************************
// Field positions
// ****************************************************************
`define SACR_BIT_VREF_ON    7
`define SACR_BIT_P6_GUARD   6
`define SACR_BIT_P4_GUARD   5
`define SACR_BIT_WD_GUARD   4
`define SACR_BIT_CK_GUARD   2
`define SACR_BIT_PW1_GUARD  1
`define SACR_BIT_PW0_GUARD  0
`define SACR_BIT_FAST       7
`define SACR_BIT_NOEXEC     6
`define SACR_BIT_ULTRA      5
`define SACR_BIT_P6SCOPE    2
`define SACR_BIT_RSTPIN     1
`define SACR_BIT_DEBUG      0
`define SACR_BIT_BREAK      4
`define SACR_BIT_START      7
`define SACR_BIT_STOP       6

// P6.0 function codes
`define SACR_P60_GPIO       2'b00
`define SACR_P60_MCK        2'b01
`define SACR_P60_MCK2       2'b10
`define SACR_P60_MCK4       2'b11

`endif

// file: hw/sacr_regs.v
// System and auxiliary control register bank on the special function register bus
`timescale 1ns/1ps
`include "sacr_defines.vh"

module sacr_regs (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [7:0]  sfr_addr,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    input  wire [7:0]  sfr_wdata,
    input  wire        page_priv,
    output reg  [7:0]  sfr_rdata,
    output wire        sfr_hit,
    input  wire        wr_guarded_p6,
    input  wire        wr_guarded_p4,
    input  wire        wr_guarded_wdt,
    input  wire        wr_guarded_ck0,
    input  wire        wr_guarded_pw1,
    input  wire        wr_guarded_pw0,
    output wire        wr_allow_p6,
    output wire        wr_allow_p4,
    output wire        wr_allow_wdt,
    output wire        wr_allow_ck0,
    output wire        wr_allow_pw1,
    output wire        wr_allow_pw0,
    input  wire        rst_is_hard,
    input  wire        any_reset_evt,
    output wire        port6_reset,
    input  wire        clk_src_ext,
    input  wire        master_clock_in,
    output reg         pin60_out,
    output wire        pin60_oe,
    output wire        pin60_is_clk_in,
    input  wire        pwm_break_src,
    output wire        pwm_break_flag,
    output wire        pwm_block,
    input  wire        bus_start_evt,
    input  wire        bus_stop_evt,
    output wire        vref_on,
    output wire        fast_mode_on,
    output wire        ultra_fast_on,
    output wire        prog_region_no_exec,
    output wire        reset_pin_select,
    output wire        debug_pins_on,
    output wire        irq1_polarity,
    output wire        irq0_polarity,
    output wire [1:0]  crc_port_sel,
    output wire        pointer_select,
    output wire        tmr1_fast_clk,
    output wire        tmr0_fast_clk,
    output wire        tmr1_clkout_on,
    output wire        tmr0_clkout_on
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [7:0] pwr3_ff;
    reg [7:0] prot_ff;
    reg [7:0] dev0_ff;
    reg [7:0] aux0_ff;
    reg [7:0] aux1_ff;
    reg [7:0] aux2_ff;
    reg       port6_rst_ff;
    reg [1:0] mck_div_ff;

    wire wr_pwr3 = sfr_wr && page_priv && (sfr_addr == `SACR_ADDR_PWR3);
    wire wr_prot = sfr_wr && page_priv && (sfr_addr == `SACR_ADDR_PROT);
    wire wr_dev0 = sfr_wr && page_priv && (sfr_addr == `SACR_ADDR_DEV0);
    // Aux registers live on ordinary pages only
    wire wr_aux0 = sfr_wr && !page_priv && (sfr_addr == `SACR_ADDR_AUX0);
    wire wr_aux1 = sfr_wr && !page_priv && (sfr_addr == `SACR_ADDR_AUX1);
    wire wr_aux2 = sfr_wr && !page_priv && (sfr_addr == `SACR_ADDR_AUX2);

    // Software break trigger: writing one to the flag bit
    wire brk_sw = wr_aux0 && sfr_wdata[`SACR_BIT_BREAK];

    reg [7:0] nxt_aux0;
    reg [7:0] nxt_aux2;

    always @* begin
        nxt_aux0 = aux0_ff;
        if (wr_aux0) begin
            nxt_aux0 = sfr_wdata & `SACR_MASK_AUX0;
        end
        if (pwm_break_src || brk_sw) begin
            nxt_aux0[`SACR_BIT_BREAK] = 1'b1;
        end else if (!wr_aux0) begin
            nxt_aux0[`SACR_BIT_BREAK] = aux0_ff[`SACR_BIT_BREAK];
        end
    end

    always @* begin
        nxt_aux2 = aux2_ff;
        if (wr_aux2) begin
            // Writing one to a flag keeps it; only zero clears
            nxt_aux2 = (sfr_wdata & `SACR_MASK_AUX2 & 8'h0F) |
                       (sfr_wdata & aux2_ff & 8'hC0);
        end
        if (bus_start_evt) begin
            nxt_aux2[`SACR_BIT_START] = 1'b1;
        end
        if (bus_stop_evt) begin
            nxt_aux2[`SACR_BIT_STOP] = 1'b1;
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwr3_ff <= `SACR_RST_PWR3;
            prot_ff <= `SACR_RST_PROT;
            dev0_ff <= `SACR_RST_DEV0;
            aux0_ff <= `SACR_RST_AUX0;
            aux1_ff <= `SACR_RST_AUX1;
            aux2_ff <= `SACR_RST_AUX2;
        end else begin
            if (wr_pwr3) begin
                pwr3_ff <= sfr_wdata & `SACR_MASK_PWR3;
            end
            if (wr_prot) begin
                prot_ff <= sfr_wdata & `SACR_MASK_PROT;
            end
            if (wr_dev0) begin
                dev0_ff <= sfr_wdata & `SACR_MASK_DEV0;
            end
            aux0_ff <= nxt_aux0;
            if (wr_aux1) begin
                aux1_ff <= sfr_wdata & `SACR_MASK_AUX1;
            end
            aux2_ff <= nxt_aux2;
        end
    end

    // ****************************************************************
    // Write protection of guarded registers
    // ****************************************************************
    // Ordinary page write gated by guard
    assign wr_allow_p6  = wr_guarded_p6  && (page_priv || !prot_ff[`SACR_BIT_P6_GUARD]);
    assign wr_allow_p4  = wr_guarded_p4  && (page_priv || !prot_ff[`SACR_BIT_P4_GUARD]);
    assign wr_allow_wdt = wr_guarded_wdt && (page_priv || !prot_ff[`SACR_BIT_WD_GUARD]);
    assign wr_allow_ck0 = wr_guarded_ck0 && (page_priv || !prot_ff[`SACR_BIT_CK_GUARD]);
    assign wr_allow_pw1 = wr_guarded_pw1 && (page_priv || !prot_ff[`SACR_BIT_PW1_GUARD]);
    assign wr_allow_pw0 = wr_guarded_pw0 && (page_priv || !prot_ff[`SACR_BIT_PW0_GUARD]);

    // ****************************************************************
    // Port 6 reset scope
    // ****************************************************************
    // Soft resets spare port 6 when scope bit set
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port6_rst_ff <= 1'b0;
        end else begin
            port6_rst_ff <= rst_is_hard ||
                            (any_reset_evt && !dev0_ff[`SACR_BIT_P6SCOPE]);
        end
    end
    assign port6_reset = port6_rst_ff;

    // ****************************************************************
    // P6.0 clock output
    // ****************************************************************
    // Divider counts master clock edges seen as a synchronous level
    reg mck_q_ff;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mck_q_ff   <= 1'b0;
            mck_div_ff <= 2'b00;
        end else begin
            mck_q_ff <= master_clock_in;
            if (master_clock_in && !mck_q_ff) begin
                mck_div_ff <= mck_div_ff + 2'b01;
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin60_out <= 1'b0;
        end else begin
            case (aux0_ff[7:6])
                `SACR_P60_MCK:  pin60_out <= master_clock_in;
                `SACR_P60_MCK2: pin60_out <= mck_div_ff[0];
                `SACR_P60_MCK4: pin60_out <= mck_div_ff[1];
                default:        pin60_out <= 1'b0;
            endcase
        end
    end
    assign pin60_oe        = !clk_src_ext && (aux0_ff[7:6] != `SACR_P60_GPIO);
    assign pin60_is_clk_in = clk_src_ext;

    // ****************************************************************
    // Read path and control outputs
    // ****************************************************************
    // Reads never blocked by guards
    assign sfr_hit = page_priv ?
        ((sfr_addr == `SACR_ADDR_PWR3) || (sfr_addr == `SACR_ADDR_PROT) ||
         (sfr_addr == `SACR_ADDR_DEV0)) :
        ((sfr_addr == `SACR_ADDR_AUX0) || (sfr_addr == `SACR_ADDR_AUX1) ||
         (sfr_addr == `SACR_ADDR_AUX2));

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && page_priv) begin
            case (sfr_addr)
                `SACR_ADDR_PWR3: sfr_rdata <= pwr3_ff;
                `SACR_ADDR_PROT: sfr_rdata <= prot_ff;
                `SACR_ADDR_DEV0: sfr_rdata <= dev0_ff;
                default:         sfr_rdata <= 8'h00;
            endcase
        end else if (sfr_rd) begin
            case (sfr_addr)
                `SACR_ADDR_AUX0: sfr_rdata <= aux0_ff;
                `SACR_ADDR_AUX1: sfr_rdata <= aux1_ff;
                `SACR_ADDR_AUX2: sfr_rdata <= aux2_ff;
                default:         sfr_rdata <= 8'h00;
            endcase
        end
    end

    assign vref_on             = pwr3_ff[`SACR_BIT_VREF_ON];
    // Speed bits are software's responsibility to order
    assign fast_mode_on        = dev0_ff[`SACR_BIT_FAST];
    assign ultra_fast_on       = dev0_ff[`SACR_BIT_ULTRA];
    assign prog_region_no_exec = dev0_ff[`SACR_BIT_NOEXEC];
    assign reset_pin_select    = dev0_ff[`SACR_BIT_RSTPIN];
    assign debug_pins_on       = dev0_ff[`SACR_BIT_DEBUG];
    assign pwm_break_flag      = aux0_ff[`SACR_BIT_BREAK];
    assign pwm_block           = aux0_ff[`SACR_BIT_BREAK];
    assign irq1_polarity       = aux0_ff[1];
    assign irq0_polarity       = aux0_ff[0];
    assign crc_port_sel        = aux1_ff[5:4];
    assign pointer_select      = aux1_ff[0];
    assign tmr1_fast_clk       = aux2_ff[3];
    assign tmr0_fast_clk       = aux2_ff[2];
    assign tmr1_clkout_on      = aux2_ff[1];
    assign tmr0_clkout_on      = aux2_ff[0];

endmodule // sacr_regs

// file: verification/sacr_regs_props.sv
// Port-level assertions for the aux control register bank
`timescale 1ns/1ps
module sacr_regs_props (
    input wire       core_clk, rst, sfr_wr, sfr_rd, page_priv, sfr_hit,
    input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata,
    input wire       wr_guarded_p6, wr_allow_p6, rst_is_hard, port6_reset,
    input wire       clk_src_ext, pin60_oe, pin60_is_clk_in,
    input wire       pwm_break_src, pwm_break_flag, pwm_block,
    input wire       vref_on, fast_mode_on, debug_pins_on, irq1_polarity, tmr1_fast_clk
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire wr_p = sfr_wr && page_priv;
    wire wr_0 = sfr_wr && !page_priv;

    a_vref_write: assert property (
        wr_p && sfr_addr == 8'h45 |=> vref_on == $past(sfr_wdata[7])) else $error("vref bit");
    a_dev_write: assert property (
        wr_p && sfr_addr == 8'h4C |=> fast_mode_on == $past(sfr_wdata[7])
        && debug_pins_on == $past(sfr_wdata[0])) else $error("device bits");
    a_wrong_page: assert property (
        wr_0 && sfr_addr == 8'h4C |=> $stable(fast_mode_on)) else $error("wrong page write");
    a_priv_allow: assert property (
        page_priv && wr_guarded_p6 |-> wr_allow_p6) else $error("page P write refused");
    a_allow_cause: assert property (
        wr_allow_p6 |-> wr_guarded_p6) else $error("allow without request");
    a_hard_reset: assert property (
        rst_is_hard |=> port6_reset) else $error("port 6 not reset");
    a_ext_clock: assert property (
        clk_src_ext |-> pin60_is_clk_in && !pin60_oe) else $error("pin60 driven in ext mode");
    a_break_set: assert property (
        pwm_break_src |=> pwm_break_flag && pwm_block) else $error("break not set");
    a_break_hold: assert property (
        pwm_break_flag && !(wr_0 && sfr_addr == 8'hA1) |=> pwm_break_flag)
        else $error("break dropped");
    a_pol_write: assert property (
        wr_0 && sfr_addr == 8'hA1 |=> irq1_polarity == $past(sfr_wdata[1])) else $error("pol");
    a_tmr_write: assert property (
        wr_0 && sfr_addr == 8'hA3 |=> tmr1_fast_clk == $past(sfr_wdata[3])) else $error("tmr");
    a_unmapped_rd: assert property (
        sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped read");
endmodule // sacr_regs_props

bind sacr_regs sacr_regs_props chk_i (
    .core_clk(core_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .page_priv(page_priv),
    .sfr_hit(sfr_hit), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .wr_guarded_p6(wr_guarded_p6), .wr_allow_p6(wr_allow_p6), .rst_is_hard(rst_is_hard),
    .port6_reset(port6_reset), .clk_src_ext(clk_src_ext), .pin60_oe(pin60_oe),
    .pin60_is_clk_in(pin60_is_clk_in), .pwm_break_src(pwm_break_src),
    .pwm_break_flag(pwm_break_flag), .pwm_block(pwm_block), .vref_on(vref_on),
    .fast_mode_on(fast_mode_on), .debug_pins_on(debug_pins_on),
    .irq1_polarity(irq1_polarity), .tmr1_fast_clk(tmr1_fast_clk)
);

// file: verification/sacr_core_model.sv
// Behavioural processor core issuing special function register bus cycles
`timescale 1ns/1ps
module sacr_core_model (
    input  wire        core_clk,
    input  wire  [7:0] sfr_rdata,
    output logic [7:0] sfr_addr = 8'h00,
    output logic [7:0] sfr_wdata = 8'h00,
    output logic       sfr_wr = 1'b0,
    output logic       sfr_rd = 1'b0,
    output logic       page_priv = 1'b0
);
    task automatic cyc(input logic w, input logic p, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge core_clk);
        #1;
        page_priv = p;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge core_clk);
        #1;
        q = sfr_rdata;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        // Released lines float: show the inverse, never a stale copy
        sfr_addr = ~sfr_addr;
        sfr_wdata = ~sfr_wdata;
    endtask
endmodule // sacr_core_model

// file: verification/sacr_regs_tb.sv
// Self-checking bench for the aux control register bank
`timescale 1ns/1ps
module sacr_regs_tb;
    typedef struct {logic p; logic [7:0] a; logic [7:0] wd; logic [7:0] ex; logic [7:0] rv;} sacr_row_t;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       ext = 1'b0;
    logic       master_clock = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [5:0] gq = 6'h00;
    logic [7:0] rd;
    wire  [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    wire        sfr_wr, sfr_rd, page_priv, p6r, oe, isck, blk, pin60;
    wire  [5:0] al;
    wire  [14:0] outs;
    int         n_errors = 0;
    int         tests_run = 0;
    logic [7:0] gmask [6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
    sacr_row_t  rows [6] = '{'{1'b1, 8'h45, 8'h80, 8'h80, 8'h00}, '{1'b1, 8'h48, 8'h77, 8'h77, 8'h00},
        '{1'b1, 8'h4C, 8'hE7, 8'hE7, 8'h83}, '{1'b0, 8'hA1, 8'hC3, 8'hC3, 8'h00},
        '{1'b0, 8'hA2, 8'h31, 8'h31, 8'h00}, '{1'b0, 8'hA3, 8'h0F, 8'h0F, 8'h00}};

    sacr_core_model core (.core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .page_priv(page_priv));
    sacr_regs uut (
        .core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .page_priv(page_priv), .sfr_rdata(sfr_rdata), .sfr_hit(),
        .wr_guarded_p6(gq[5]), .wr_guarded_p4(gq[4]), .wr_guarded_wdt(gq[3]),
        .wr_guarded_ck0(gq[2]), .wr_guarded_pw1(gq[1]), .wr_guarded_pw0(gq[0]),
        .wr_allow_p6(al[5]), .wr_allow_p4(al[4]), .wr_allow_wdt(al[3]),
        .wr_allow_ck0(al[2]), .wr_allow_pw1(al[1]), .wr_allow_pw0(al[0]),
        .rst_is_hard(ev[4]), .any_reset_evt(ev[3]), .port6_reset(p6r), .clk_src_ext(ext),
        .master_clock_in(master_clock), .pin60_out(pin60), .pin60_oe(oe), .pin60_is_clk_in(isck),
        .pwm_break_src(ev[2]), .pwm_break_flag(), .pwm_block(blk), .bus_start_evt(ev[1]),
        .bus_stop_evt(ev[0]), .vref_on(outs[14]), .fast_mode_on(outs[13]),
        .ultra_fast_on(outs[12]), .prog_region_no_exec(outs[11]), .reset_pin_select(outs[10]),
        .debug_pins_on(outs[9]), .irq1_polarity(outs[8]), .irq0_polarity(outs[7]),
        .crc_port_sel(outs[6:5]), .pointer_select(outs[4]), .tmr1_fast_clk(outs[3]),
        .tmr0_fast_clk(outs[2]), .tmr1_clkout_on(outs[1]), .tmr0_clkout_on(outs[0]));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) #1 master_clock = ~master_clock;

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
        core.cyc(1'b1, p, a, d, rd);
    endtask
    task automatic rdc(input logic p, input logic [7:0] a, input logic [7:0] e, input string nm);
        core.cyc(1'b0, p, a, 8'h00, rd);
        chk(nm, rd, e);
    endtask
    // One-cycle event pulse; result sampled right after it is taken
    task automatic kick(input logic [4:0] v);
        @(posedge core_clk);
        #1 ev = v;
        @(posedge core_clk);
        #1 ev = 5'h00;
    endtask
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst = 1'b0;
        foreach (rows[i]) rdc(rows[i].p, rows[i].a, rows[i].rv, "reset value");
        // Write and read back each writable mask, AUX0 without bits 5:4 and AUX2 without bits 7:6; reserved bits are written as zero
        foreach (rows[i]) begin
            wr(rows[i].p, rows[i].a, rows[i].wd);
            rdc(rows[i].p, rows[i].a, rows[i].ex, "readback");
        end
        chk("ctrl outputs", outs[14:7], 8'hFF);
        chk("aux outputs", {1'b0, outs[6:0]}, 8'h7F);
        $display("Register table test done");
        for (int i = 0; i < 6; i++) begin
            wr(1'b1, 8'h48, gmask[i]);
            gq = 6'h3F;
            core.page_priv = 1'b0;
            #1 chk("allow page 0", {2'b00, al}, {2'b00, ~(6'h20 >> i)});
            core.page_priv = 1'b1;
            #1 chk("allow page P", {2'b00, al}, 8'h3F);
            gq = 6'h00;
        end
        wr(1'b0, 8'h45, 8'h00);
        rdc(1'b1, 8'h45, 8'h80, "page 0 write");
        rdc(1'b1, 8'h46, 8'h00, "unmapped read");
        $display("Protection test done");
        kick(5'h02);
        rdc(1'b0, 8'hA3, 8'h8F, "start flag");
        kick(5'h01);
        rdc(1'b0, 8'hA3, 8'hCF, "stop flag");
        wr(1'b0, 8'hA3, 8'h0F);
        rdc(1'b0, 8'hA3, 8'h0F, "flags cleared");
        kick(5'h04);
        chk("break block", {7'h00, blk}, 8'h01);
        rdc(1'b0, 8'hA1, 8'hD3, "break flag");
        wr(1'b0, 8'hA1, 8'hC3);
        rdc(1'b0, 8'hA1, 8'hC3, "break cleared");
        $display("Flag test done");
        kick(5'h08);
        chk("p6 scoped", {7'h00, p6r}, 8'h00);
        kick(5'h18);
        chk("p6 hard", {7'h00, p6r}, 8'h01);
        wr(1'b1, 8'h4C, 8'h83);
        kick(5'h08);
        chk("p6 all", {7'h00, p6r}, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(1'b0, 8'hA1, {c[1:0], 6'h00});
            #1 chk("pin60 drive", {7'h00, oe}, {7'h00, c != 0});
            if (c < 2) begin
                // Pin follows the sampled clock, so it lags the toggle after the edge
                @(posedge core_clk);
                #2 chk("pin60 out", {7'h00, pin60}, {7'h00, (c == 1) & ~master_clock});
            end
        end
        @(posedge core_clk);
        #1 ext = 1'b1;
        #1 chk("pin60 ext", {6'h00, oe, isck}, 8'h01);
        @(posedge core_clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        rdc(1'b1, 8'h4C, 8'h83, "dev0 after reset");
        $display("Pin and reset test done");
        final_report;
    end

    // Run needs about 110 cycles of 4 ns; allow over forty times that
    initial begin
        #20000;
        n_errors++;
        final_report;
    end
endmodule // sacr_regs_tb
